// ### hdl/see_slave.sv
// serial eeprom slave: link logic on sck, array and write timer on clk
//
// Overview of operation
// - serial link runs only modes 0 and 3
// - 16384 bytes, 64-byte pages
// - byte, partial or full page writes
// - self-timed programming within 5 ms
// - protect quarter, half or whole array
// - extra 64-byte id page, lockable
// - suspend input pauses, release resumes sequence
// - reset ignores commands, then standby
// - standby only after programming finishes
// - bytes shifted msb first both ways
// - first byte is command, unknown ignored
// - sample on rising, drive on falling
// - select rise ends or launches operation
// - busy accepts only status read
`timescale 1ns/1ps
module see_slave #(
    parameter int unsigned PROG_CYC = see_pkg::PROG_CYCLES
) (
    // system
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // serial link
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_o,
    input  wire logic wp_n_i,
    input  wire logic hold_n_i,
    // state
    output logic      busy_o,
    output logic      standby_o
);
    import see_pkg::*;

    localparam int unsigned TMR_W = $clog2(PROG_CYC + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYC - 1);

    // array and id page, written only by the clk side
    logic [7:0] mem_q [MEM_BYTES];
    logic [7:0] id_q [PAGE_BYTES];
    logic [7:0] wbuf_q [PAGE_BYTES];

    // sck side: frame state, cleared whenever select is high
    see_phase_type   phase_q, phase_d;
    logic [2:0]      bit_q, bit_d;
    logic [6:0]      sh_q, sh_d;
    logic [7:0]      cmd_q, cmd_d;
    logic [13:0]     addr_q, addr_d;
    logic [7:0]      tx_q, tx_d;
    logic            so_q;
    // sck side: what the frame left behind for the clk side
    logic [7:0]      op_q, op_d;
    logic [13:0]     start_q, start_d;
    logic [63:0]     mask_q, mask_d;
    logic            done_q, done_d;
    logic            wb_we;
    logic [5:0]      wb_idx;
    // status brought into the sck side
    logic [5:0]      st_m_q, st_s_q;
    // clk side
    see_prog_type    pst_q, pst_d;
    logic            cs_m_q, cs_s_q, cs_p_q;
    logic            wp_m_q, wp_s_q;
    logic            wen_q, wen_d;
    logic [1:0]      bp_q, bp_d;
    logic            wpen_q, wpen_d;
    logic            lock_q, lock_d;
    logic [7:0]      kind_q, kind_d;
    logic [13:0]     pstart_q, pstart_d;
    logic [63:0]     pmask_q, pmask_d;
    logic [6:0]      cnt_q, cnt_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic            mem_we, id_we;

    logic            frame_rst;
    logic [7:0]      rx_byte;
    logic [7:0]      stat_byte;
    logic            cs_rise;
    logic            busy_s;

    function automatic logic prot(input logic [1:0] bp, input logic [13:0] a);
        case (bp)
            2'h1:    prot = (a >= BP_QUARTER);
            2'h2:    prot = (a >= BP_HALF);
            2'h3:    prot = 1'b1;
            default: prot = 1'b0;
        endcase
    endfunction

    // select high is the frame's own end; the clock may be stopped then
    assign frame_rst = cs_n_i | ~rst_n_i;
    assign rx_byte   = {sh_q, si_i};
    assign busy_s    = st_s_q[0];
    assign stat_byte = {st_s_q[3], 3'h0, st_s_q[2:1], st_s_q[4], busy_s};

    // status levels are quasi-static between frames; eight command
    // clocks flush the two stages before they are looked at
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_m_q <= 6'h0;
            st_s_q <= 6'h0;
        end else begin
            st_m_q <= {lock_q, wen_q, wpen_q, bp_q, busy_o};
            st_s_q <= st_m_q;
        end
    end

    function automatic logic [7:0] next_tx(input logic [7:0] c, input logic [13:0] a,
                                           input logic [7:0] s, input logic l);
        case (c)
            OP_READ: next_tx = mem_q[a];
            OP_RDID: next_tx = id_q[a[5:0]];
            OP_RDLS: next_tx = {7'h0, l};
            default: next_tx = s;
        endcase
    endfunction

    always_comb begin
        phase_d = phase_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        cmd_d   = cmd_q;
        addr_d  = addr_q;
        tx_d    = tx_q;
        op_d    = op_q;
        start_d = start_q;
        mask_d  = mask_q;
        done_d  = done_q;
        wb_we   = 1'b0;
        wb_idx  = addr_q[5:0];
        // clocks with suspend low are not seen at all
        if (hold_n_i) begin
            bit_d = bit_q + 3'h1;
            sh_d  = rx_byte[6:0];
            // a started byte cancels any completed operation
            if (bit_q == 3'h0) begin
                done_d = 1'b0;
                if (phase_q == PH_CMD) begin
                    op_d = OP_NONE;
                end
            end
            if (bit_q == LAST_BIT) begin
                case (phase_q)
                    PH_CMD: begin
                        cmd_d   = rx_byte;
                        phase_d = PH_IGN;
                        if (busy_s) begin
                            if (rx_byte == OP_RDSR) begin
                                phase_d = PH_OUT;
                                tx_d    = stat_byte;
                            end
                        end else begin
                            case (rx_byte)
                                OP_WREN, OP_WRDI, OP_LOCK: begin
                                    op_d   = rx_byte;
                                    done_d = 1'b1;
                                end
                                OP_RDSR, OP_RDLS: begin
                                    phase_d = PH_OUT;
                                    tx_d    = next_tx(rx_byte, addr_q, stat_byte, st_s_q[5]);
                                end
                                OP_WRSR: begin
                                    op_d    = rx_byte;
                                    mask_d  = 64'h0;
                                    addr_d  = 14'h0;
                                    phase_d = PH_DIN;
                                end
                                OP_READ, OP_WRIT, OP_RDID, OP_WRID: begin
                                    phase_d = PH_AHI;
                                end
                                default: phase_d = PH_IGN;
                            endcase
                        end
                    end
                    PH_AHI: begin
                        addr_d  = {rx_byte[5:0], 8'h0};
                        phase_d = PH_ALO;
                    end
                    PH_ALO: begin
                        addr_d = {addr_q[13:8], rx_byte};
                        if (cmd_q == OP_READ || cmd_q == OP_RDID) begin
                            tx_d    = next_tx(cmd_q, {addr_q[13:8], rx_byte}, stat_byte, st_s_q[5]);
                            addr_d  = {addr_q[13:8], rx_byte} + 14'h1;
                            phase_d = PH_OUT;
                        end else begin
                            op_d    = cmd_q;
                            start_d = {addr_q[13:8], rx_byte};
                            mask_d  = 64'h0;
                            phase_d = PH_DIN;
                        end
                    end
                    PH_DIN: begin
                        // later bytes overwrite earlier ones in the same page
                        wb_we          = 1'b1;
                        mask_d[wb_idx] = 1'b1;
                        done_d         = 1'b1;
                        addr_d         = {addr_q[13:6], addr_q[5:0] + 6'h1};
                        if (cmd_q == OP_WRSR) begin
                            phase_d = PH_IGN;
                        end
                    end
                    PH_OUT: begin
                        tx_d   = next_tx(cmd_q, addr_q, stat_byte, st_s_q[5]);
                        addr_d = addr_q + 14'h1;
                    end
                    default: phase_d = PH_IGN;
                endcase
            end
        end
    end

    // sampling on the rising edge serves modes 0 and 3 alike
    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            phase_q <= PH_CMD;
            bit_q   <= 3'h0;
            sh_q    <= 7'h0;
            cmd_q   <= OP_NONE;
            addr_q  <= 14'h0;
            tx_q    <= 8'h0;
        end else begin
            phase_q <= phase_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            cmd_q   <= cmd_d;
            addr_q  <= addr_d;
            tx_q    <= tx_d;
        end
    end

    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q    <= OP_NONE;
            start_q <= 14'h0;
            mask_q  <= 64'h0;
            done_q  <= 1'b0;
        end else begin
            op_q    <= op_d;
            start_q <= start_d;
            mask_q  <= mask_d;
            done_q  <= done_d;
        end
    end

    always_ff @(posedge sck_i) begin
        if (wb_we) begin
            wbuf_q[wb_idx] <= rx_byte;
        end
    end

    // output changes on the falling edge, msb first
    always_ff @(negedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            so_q <= 1'b0;
        end else if (hold_n_i && phase_q == PH_OUT) begin
            so_q <= tx_q[~bit_q];
        end
    end

    assign so_o    = so_q;
    assign so_oe_o = ~cs_n_i & hold_n_i & (phase_q == PH_OUT);

    // clk side: select and write-protect pins through two stages
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_p_q <= 1'b1;
            wp_m_q <= 1'b1;
            wp_s_q <= 1'b1;
        end else begin
            cs_m_q <= cs_n_i;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
            wp_m_q <= wp_n_i;
            wp_s_q <= wp_m_q;
        end
    end

    // frame results are stable once select is high and the clock stopped
    assign cs_rise = cs_s_q & ~cs_p_q;

    always_comb begin
        pst_d    = pst_q;
        wen_d    = wen_q;
        bp_d     = bp_q;
        wpen_d   = wpen_q;
        lock_d   = lock_q;
        kind_d   = kind_q;
        pstart_d = pstart_q;
        pmask_d  = pmask_q;
        cnt_d    = cnt_q;
        tmr_d    = tmr_q;
        mem_we   = 1'b0;
        id_we    = 1'b0;
        case (pst_q)
            PS_IDLE: begin
                cnt_d = 7'h0;
                tmr_d = '0;
                if (cs_rise && done_q) begin
                    kind_d   = op_q;
                    pstart_d = start_q;
                    pmask_d  = mask_q;
                    case (op_q)
                        OP_WREN: wen_d = 1'b1;
                        OP_WRDI: wen_d = 1'b0;
                        OP_WRSR: begin
                            if (wen_q && !(wpen_q && !wp_s_q)) begin
                                bp_d   = wbuf_q[0][ST_BP1:ST_BP0];
                                wpen_d = wbuf_q[0][ST_WPEN];
                                wen_d  = 1'b0;
                                pst_d  = PS_PROG;
                            end
                        end
                        OP_WRIT: begin
                            if (wen_q && !prot(bp_q, start_q)) begin
                                wen_d = 1'b0;
                                pst_d = PS_PROG;
                            end
                        end
                        OP_WRID, OP_LOCK: begin
                            // locking is one-way
                            if (wen_q && !lock_q) begin
                                lock_d = (op_q == OP_LOCK);
                                wen_d  = 1'b0;
                                pst_d  = PS_PROG;
                            end
                        end
                        default: pst_d = PS_IDLE;
                    endcase
                end
            end
            PS_PROG: begin
                // copy the page first, then sit out the rest of the write time, counted from the first copy cycle
                tmr_d = tmr_q + 1'b1;
                if (!cnt_q[6]) begin
                    cnt_d  = cnt_q + 7'h1;
                    mem_we = pmask_q[cnt_q[5:0]] && kind_q == OP_WRIT;
                    id_we  = pmask_q[cnt_q[5:0]] && kind_q == OP_WRID;
                end
                if (tmr_q == TMR_LAST) begin
                    pst_d = PS_IDLE;
                end
            end
            default: pst_d = PS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pst_q    <= PS_IDLE;
            wen_q    <= 1'b0;
            bp_q     <= BP_RESET;
            wpen_q   <= 1'b0;
            lock_q   <= 1'b0;
            kind_q   <= OP_NONE;
            pstart_q <= 14'h0;
            pmask_q  <= 64'h0;
            cnt_q    <= 7'h0;
            tmr_q    <= '0;
        end else begin
            pst_q    <= pst_d;
            wen_q    <= wen_d;
            bp_q     <= bp_d;
            wpen_q   <= wpen_d;
            lock_q   <= lock_d;
            kind_q   <= kind_d;
            pstart_q <= pstart_d;
            pmask_q  <= pmask_d;
            cnt_q    <= cnt_d;
            tmr_q    <= tmr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_q[{pstart_q[13:6], cnt_q[5:0]}] <= wbuf_q[cnt_q[5:0]];
        end
        if (id_we) begin
            id_q[cnt_q[5:0]] <= wbuf_q[cnt_q[5:0]];
        end
    end

    assign busy_o    = (pst_q == PS_PROG);
    assign standby_o = cs_s_q & (pst_q == PS_IDLE);
endmodule

// ### shared/see_pkg.sv
// constants for the serial eeprom slave
package see_pkg;
    localparam int unsigned MEM_BYTES  = 16384;
    localparam int unsigned PAGE_BYTES = 64;
    localparam int unsigned ADDR_W     = 14;
    localparam int unsigned COL_W      = 6;
    // instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRIT = 8'h02;
    localparam logic [7:0] OP_RDID = 8'h83;
    localparam logic [7:0] OP_WRID = 8'h82;
    localparam logic [7:0] OP_RDLS = 8'h85;
    localparam logic [7:0] OP_LOCK = 8'h8a;
    localparam logic [7:0] OP_NONE = 8'h00;
    // status byte fields
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_WEN  = 1;
    localparam int unsigned ST_BP0  = 2;
    localparam int unsigned ST_BP1  = 3;
    localparam int unsigned ST_WPEN = 7;
    // protected region starts
    localparam logic [13:0] BP_QUARTER = 14'h3000;
    localparam logic [13:0] BP_HALF    = 14'h2000;
    localparam logic [1:0]  BP_RESET   = 2'h0;
    // self-timed programming
    localparam int unsigned PROG_TIME_US = 5000;
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    typedef enum logic [2:0] {
        PH_CMD, PH_AHI, PH_ALO, PH_DIN, PH_OUT, PH_IGN
    } see_phase_type;
    typedef enum logic [0:0] {
        PS_IDLE, PS_PROG
    } see_prog_type;
endpackage

// ### dv/see_slave_sva.sv
// concurrent checks on the serial eeprom slave ports
`timescale 1ns/1ps
module see_slave_sva #(
    parameter int unsigned PROG_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic wp_n_i,
    input wire logic hold_n_i,
    input wire logic busy_o,
    input wire logic standby_o
);
    import see_pkg::*;
    logic [31:0] cnt_q, cnt_d;
    logic [5:0]  bits_q, bits_d;
    logic [7:0]  cmd_q, cmd_d;
    always_comb begin
        cnt_d  = busy_o ? cnt_q + 32'h1 : 32'h0;
        bits_d = (bits_q == 6'h3f) ? bits_q : bits_q + 6'h1;
        cmd_d  = (bits_q < 6'h8) ? {cmd_q[6:0], si_i} : cmd_q;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // frame view rebuilt on sck, cleared by deselect as in the slave
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bits_q <= 6'h0;
            cmd_q  <= 8'h0;
        end else if (hold_n_i) begin
            bits_q <= bits_d;
            cmd_q  <= cmd_d;
        end
    end
    sequence s_sel_held;
        !cs_n_i [*4];
    endsequence
    sequence s_prog_done;
        $fell(busy_o) ##0 cs_n_i;
    endsequence
    a_oe_sel_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) cs_n_i |-> !so_oe_o)
        else $error("so enabled while deselected");
    a_oe_hold_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) !hold_n_i |-> !so_oe_o)
        else $error("so enabled during suspend");
    a_busy_no_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i) busy_o |-> !standby_o)
        else $error("standby while programming");
    a_sel_ends_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i) s_sel_held |-> !standby_o)
        else $error("standby while selected");
    a_standby_return: assert property (@(posedge clk_i) disable iff (!rst_n_i) s_prog_done |-> ##[0:3] standby_o)
        else $error("no standby after programming");
    a_busy_after_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) $rose(busy_o) |-> $past(cs_n_i, 2))
        else $error("programming began inside a frame");
    a_prog_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i) busy_o |-> cnt_q <= PROG_CYC)
        else $error("programming runs too long");
    a_prog_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> cnt_q >= PROG_CYC - 1 && cnt_q <= PROG_CYC + 1)
        else $error("programming length wrong");
    a_so_on_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !cs_n_i && $changed(so_o) |-> !sck_i)
        else $error("so changed while sck high");
    a_oe_after_cmd: assert property (@(negedge sck_i) disable iff (!rst_n_i || cs_n_i)
        so_oe_o |-> bits_q >= 6'h8)
        else $error("so enabled inside command byte");
    a_busy_rdsr_only: assert property (@(negedge sck_i) disable iff (!rst_n_i || cs_n_i)
        so_oe_o && busy_o |-> cmd_q == OP_RDSR)
        else $error("answer other than status while busy");
endmodule
bind see_slave see_slave_sva #(.PROG_CYC(PROG_CYC)) u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i),
    .busy_o(busy_o), .standby_o(standby_o));

// ### dv/see_spi_master.sv
// serial bus master model, mode 0 or 3
`timescale 1ns/1ps
module see_spi_master (
    // serial link
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      hold_n_o,
    input  wire logic so_i
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    initial begin
        sck_o    = 1'b0;
        cs_n_o   = 1'b1;
        si_o     = 1'b0;
        hold_n_o = 1'b1;
    end
    // sck exists only inside frames; idle level picks the mode
    task automatic run(input bit m3, input int hb);
        logic [7:0] b;
        logic [7:0] r;
        int         k;
        rxq.delete();
        k = 0;
        sck_o = m3;
        #15 cs_n_o = 1'b0;
        #15;
        while (txq.size() > 0) begin
            b = txq.pop_front();
            for (int i = 7; i >= 0; i--) begin
                sck_o = 1'b0;
                si_o = b[i];
                if (k == hb) begin
                    #5 hold_n_o = 1'b0;
                    repeat (3) begin
                        #10 si_o = ~si_o;
                        #15 sck_o = 1'b1;
                        #15 sck_o = 1'b0;
                    end
                    #5 hold_n_o = 1'b1;
                    si_o = b[i];
                end
                #15 sck_o = 1'b1;
                r = {r[6:0], so_i};
                k++;
                #15;
            end
            rxq.push_back(r);
        end
        sck_o = m3;
        #15 cs_n_o = 1'b1;
        // released data line must not keep looking valid
        si_o = ~si_o;
        #45;
    endtask
endmodule

// ### dv/see_slave_tb.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
module see_slave_tb;
    import see_pkg::*;
    localparam int unsigned PROG = 400;
    logic       clk_i   = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       wp_n_i  = 1'b1;
    logic       sck, cs_n, si, so, so_oe, hold_n, busy, standby;
    // a released so line shows the inverse, so stale data cannot pass
    wire        so_line = so_oe ? so : ~so;
    logic [7:0] rd;
    int         err_total   = 0;
    int         comparisons = 0;
    int         cyc         = 0;
    bit         oe_seen     = 1'b0;
    always #4 clk_i = ~clk_i;
    always @(posedge so_oe) oe_seen = 1'b1;
    see_spi_master u_mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so_line));
    see_slave #(.PROG_CYC(PROG)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n_i), .hold_n_i(hold_n), .busy_o(busy), .standby_o(standby));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    // n header bytes of w, then nt bytes counting from base; rd gets the last byte heard
    task automatic xf(input logic [23:0] w, input int n, input int nt, input logic [7:0] base,
                      input bit m3 = 1'b0, input int hb = -1);
        for (int i = 0; i < n; i++) begin
            u_mst.txq.push_back(w[23-8*i -: 8]);
        end
        for (int i = 0; i < nt; i++) begin
            u_mst.txq.push_back(base + 8'(i));
        end
        u_mst.run(m3, hb);
        rd = u_mst.rxq[$];
    endtask
    // refused writes may start no cycle, so the start is only checked on request
    task automatic wprog(input bit exp);
        int t;
        bit sb;
        t = 0;
        sb = 1'b0;
        while (busy !== 1'b1 && t < 8) begin
            @(negedge clk_i);
            t++;
        end
        if (exp) chk({7'h0, busy}, 8'h1);
        t = 0;
        while (busy !== 1'b0 && t < PROG + 20) begin
            @(negedge clk_i);
            sb |= (busy === 1'b1 && standby !== 1'b0);
            t++;
        end
        chk({7'h0, busy}, 8'h0);
        chk({7'h0, sb}, 8'h0);
        repeat (4) @(negedge clk_i);
        chk({7'h0, standby}, 8'h1);
    endtask
    task automatic t_modes();
        chk({6'h0, busy, standby}, 8'h1);
        xf(24'h060000, 1, 0, 8'h0, 1'b1);
        xf(24'h050000, 1, 1, 8'h0, 1'b1);
        chk(rd, 8'h02);
        xf(24'h040000, 1, 0, 8'h0);
        xf(24'h050000, 1, 2, 8'h0);
        chk(rd, 8'h00);
    endtask
    task automatic t_page();
        xf(24'h060000, 1, 0, 8'h0);
        xf(24'h02007c, 3, 6, 8'ha0);
        while (busy !== 1'b1 && cyc < 50000) @(negedge clk_i);
        oe_seen = 1'b0;
        xf(24'h030040, 3, 1, 8'h0);
        chk({7'h0, oe_seen}, 8'h0);
        xf(24'h050000, 1, 1, 8'h0);
        chk(rd, 8'h01);
        wprog(1'b0);
        xf(24'h030040, 3, 2, 8'h0);
        chk(rd, 8'ha5);
        xf(24'h03007c, 3, 4, 8'h0, 1'b1, 12);
        chk(rd, 8'ha3);
    endtask
    task automatic t_idpage();
        xf(24'h060000, 1, 0, 8'h0);
        xf(24'h820005, 3, 1, 8'h3c);
        wprog(1'b1);
        xf(24'h830005, 3, 1, 8'h0);
        chk(rd, 8'h3c);
        for (int j = 0; j < 2; j++) begin
            xf(24'h850000, 1, 1, 8'h0);
            chk(rd, 8'(j));
            xf(24'h060000, 1, 0, 8'h0);
            xf(j ? 24'h820005 : 24'h8a0000, j ? 3 : 1, j, 8'h99);
            wprog(~j[0]);
        end
        xf(24'h830005, 3, 1, 8'h0);
        chk(rd, 8'h3c);
    endtask
    task automatic t_protect();
        logic [13:0] a [3];
        logic [7:0]  e [3];
        logic [13:0] lo;
        a = '{14'h0000, BP_HALF, BP_QUARTER};
        for (int lv = 0; lv < 4; lv++) begin
            lo = (lv == 1) ? BP_QUARTER : (lv == 2) ? BP_HALF : 14'h0;
            if (lv > 0) begin
                xf(24'h060000, 1, 0, 8'h0);
                xf({8'h01, 4'h0, 2'(lv), 2'h0, 8'h0}, 2, 0, 8'h0);
                wprog(1'b1);
                xf(24'h050000, 1, 1, 8'h0);
                chk(rd, {4'h0, 2'(lv), 2'h0});
            end
            for (int j = 0; j < 3; j++) begin
                xf(24'h060000, 1, 0, 8'h0);
                xf({8'h02, 2'h0, a[j]}, 3, 1, 8'(16 * lv + j));
                wprog(lv == 0);
                if (lv == 0 || a[j] < lo) e[j] = 8'(16 * lv + j);
                xf({8'h03, 2'h0, a[j]}, 3, 1, 8'h0);
                chk(rd, e[j]);
            end
        end
    endtask
    // status register guarded by the enable bit together with a low wp pin
    task automatic t_wpen();
        xf(24'h060000, 1, 0, 8'h0);
        xf(24'h018000, 2, 0, 8'h0);
        wprog(1'b1);
        xf(24'h050000, 1, 1, 8'h0);
        chk(rd, 8'h80);
        @(negedge clk_i) wp_n_i = 1'b0;
        xf(24'h060000, 1, 0, 8'h0);
        xf(24'h010c00, 2, 0, 8'h0);
        chk({7'h0, busy}, 8'h0);
        wprog(1'b0);
        xf(24'h050000, 1, 1, 8'h0);
        chk(rd & 8'h8c, 8'h80);
        @(negedge clk_i) wp_n_i = 1'b1;
        xf(24'h060000, 1, 0, 8'h0);
        xf(24'h010000, 2, 0, 8'h0);
        wprog(1'b1);
        xf(24'h050000, 1, 1, 8'h0);
        chk(rd, 8'h00);
    endtask
    task automatic t_rst2();
        rst_n_i = 1'b0;
        xf(24'h060000, 1, 0, 8'h0);
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk({6'h0, busy, standby}, 8'h1);
        xf(24'h050000, 1, 1, 8'h0);
        chk(rd, 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_modes();
        t_page();
        t_idpage();
        t_protect();
        t_wpen();
        @(negedge clk_i);
        t_rst2();
        end_of_test();
    end
endmodule
